// ===== include/dcc_defines.svh
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// ----------------------------------------------------------------------
// control channel bit positions (vector index, channel bit 0 is msb)
// ----------------------------------------------------------------------
`define DCC_CC_STROBE_ADDR   14
`define DCC_CC_LOCK_TERM     13
`define DCC_CC_SEL_NC_DATA   12
`define DCC_CC_PAR_LEFT      11
`define DCC_CC_PAR_RIGHT     10
`define DCC_CC_SEL_CHAR_CMP  9
`define DCC_CC_SEL_BIT_CMP   8
`define DCC_CC_SEL_DBL_CMP   7
`define DCC_CC_STROBE_KB23   6
`define DCC_CC_STROBE_KB01   5

// ----------------------------------------------------------------------
// word channel select pattern fields (vector index)
// ----------------------------------------------------------------------
`define DCC_WC_LOCK_LO       15
`define DCC_WC_LOCK_HI       14
`define DCC_WC_ALERT_LO      13
`define DCC_WC_ALERT_HI      12
`define DCC_WC_BUZZ_LO       11
`define DCC_WC_BUZZ_HI       10
`define DCC_WC_POS_MSB       6
`define DCC_WC_OFFSET_BIT    15

// ----------------------------------------------------------------------
// segment allocation
// ----------------------------------------------------------------------
`define DCC_PRI_BUF_BASE     12'h000
`define DCC_SEC_BUF_BASE     12'he00
`define DCC_PRI_CUR_BASE     12'hfc0
`define DCC_SEC_CUR_BASE     12'hff8
`define DCC_UNUSED_WORD      12'hfff

// ----------------------------------------------------------------------
// compare codes and reset values
// ----------------------------------------------------------------------
`define DCC_CODE_EOF         7'h1c
`define DCC_CODE_EOR         7'h1f
`define DCC_RST_ADDR         15'h0000
`define DCC_RST_DATA         16'h0000

`endif

// ===== include/dcc_pkg.sv
package dcc_pkg;

  typedef enum logic [2:0] {
    DCC_REG_PRI_BUF = 3'h0,
    DCC_REG_SEC_BUF = 3'h1,
    DCC_REG_PRI_CUR = 3'h3,
    DCC_REG_SEC_CUR = 3'h2,
    DCC_REG_UNUSED  = 3'h6
  } dcc_region_e;

  typedef struct packed {
    dcc_region_e region;
    logic [1:0]  segment;
    logic [2:0]  unit;
    logic [8:0]  word;
  } dcc_decode_s;

  typedef struct packed {
    logic [27:0] lockout;
    logic [27:0] alert;
    logic [27:0] buzzer;
  } dcc_ind_s;

endpackage

// ===== hw/dcc_channel_ctrl.sv
`timescale 1ns/1ps
`include "dcc_defines.svh"
// Summary of operation
// - two indicator registers hold three bits for each of 28 keyboards.
// - a set indicator stays on until a later load clears its bit.
// - strobe A loads groups 0 and 1; strobe 9 loads groups 2 and 3.
// - a strobe sets selected bits and clears unselected bits of that register.
// - a lamp is chosen by one type bit plus one position bit together.
// - word bits 0-5 select lockout, alert, buzzer for lower/upper group.
// - word bits 9-F select keyboard positions one to seven in a group.
// - the lockout lamp only lights; keyboard data is untouched.
// - display memory is four 4K segments of identical layout, seven units each.
// - each unit owns a 512-word primary buffer from segment offset X000.
// - each unit owns a 64-word secondary buffer from segment offset XE00.
// - secondary cursor words sit at XFF8-XFFE by unit; XFFF unused.
// - control channel bits tell apart the four kinds of word channel content.
// - with bit 3 set, pulsing control bit 1 loads the starting address.
// - character compare accepts any 7-bit terminating character.
// - double compare ends a transfer on either 1C or 1F in the data.

module dcc_channel_ctrl
  import dcc_pkg::*;
#(
  parameter int KB_PER_GROUP = 7,
  parameter int NUM_GROUPS   = 4
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // channels from the station controller
  input  wire logic [15:0] output_word_channel,
  input  wire logic [15:0] output_control_channel,
  // block transfer data stream watched for compare
  input  wire logic [15:0] xfer_data,
  input  wire logic        xfer_valid,
  // keyboard indicators
  output dcc_ind_s         indicators,
  // display memory addressing
  output logic [14:0]      start_addr,
  output logic             offset_mode,
  output logic             addr_load,
  output dcc_decode_s      addr_decode,
  // data lines toward the display buffer unit
  output logic             nc_data_sel,
  output logic [15:0]      unit_data,
  output logic [1:0]       unit_parity,
  // compare termination
  output logic             compare_hit,
  output logic             xfer_stop
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (KB_PER_GROUP != 7 || NUM_GROUPS != 4) begin : g_size_check
    $error("dcc_channel_ctrl: only 4 groups of 7 keyboards are served");
  end

  // ----------------------------------------------------------------------
  // strobe edge tracking
  // ----------------------------------------------------------------------
  logic       prev_kb01;
  logic       prev_kb23;
  logic       prev_addr;
  logic       rise_kb01;
  logic       rise_kb23;
  logic       rise_addr;
  logic       sel_nc;

  always_comb begin
    sel_nc    = output_control_channel[`DCC_CC_SEL_NC_DATA];
    rise_kb01 = output_control_channel[`DCC_CC_STROBE_KB01] & ~prev_kb01;
    rise_kb23 = output_control_channel[`DCC_CC_STROBE_KB23] & ~prev_kb23;
    rise_addr = output_control_channel[`DCC_CC_STROBE_ADDR] & ~prev_addr;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_kb01 <= 1'b0;
      prev_kb23 <= 1'b0;
      prev_addr <= 1'b0;
    end else begin
      prev_kb01 <= output_control_channel[`DCC_CC_STROBE_KB01];
      prev_kb23 <= output_control_channel[`DCC_CC_STROBE_KB23];
      prev_addr <= output_control_channel[`DCC_CC_STROBE_ADDR];
    end
  end

  // ----------------------------------------------------------------------
  // indicator registers
  // ----------------------------------------------------------------------
  // expand one select pattern into a pair of 7-keyboard groups for a type
  function automatic logic [13:0] dcc_pair(input logic [15:0] w, input int lo_bit, input int hi_bit);
    logic [6:0] pos;
    logic [13:0] res;
    pos = '0;
    res = '0;
    for (int i = 0; i < 7; i++) begin
      pos[i] = w[`DCC_WC_POS_MSB - i];
    end
    res[6:0]  = w[lo_bit] ? pos : 7'h00;
    res[13:7] = w[hi_bit] ? pos : 7'h00;
    return res;
  endfunction

  dcc_ind_s   ind_q;
  dcc_ind_s   next_ind;
  logic [13:0] pat_lock;
  logic [13:0] pat_alert;
  logic [13:0] pat_buzz;

  always_comb begin
    pat_lock  = dcc_pair(output_word_channel, `DCC_WC_LOCK_LO, `DCC_WC_LOCK_HI);
    pat_alert = dcc_pair(output_word_channel, `DCC_WC_ALERT_LO, `DCC_WC_ALERT_HI);
    pat_buzz  = dcc_pair(output_word_channel, `DCC_WC_BUZZ_LO, `DCC_WC_BUZZ_HI);
    next_ind  = ind_q;
    if (rise_kb01) begin
      next_ind.lockout[13:0] = pat_lock;
      next_ind.alert[13:0]   = pat_alert;
      next_ind.buzzer[13:0]  = pat_buzz;
    end
    if (rise_kb23) begin
      next_ind.lockout[27:14] = pat_lock;
      next_ind.alert[27:14]   = pat_alert;
      next_ind.buzzer[27:14]  = pat_buzz;
    end
  end

  // lamp drive only; nothing here touches keyboard input paths
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ind_q <= '0;
    end else begin
      ind_q <= next_ind;
    end
  end

  assign indicators = ind_q;

  // ----------------------------------------------------------------------
  // starting address and memory map decode
  // ----------------------------------------------------------------------
  function automatic dcc_decode_s dcc_map(input logic [14:0] a);
    dcc_decode_s d;
    logic [11:0] off;
    logic [11:0] rel;
    off       = a[11:0];
    rel       = '0;
    d.segment = a[13:12];
    d.region  = DCC_REG_UNUSED;
    d.unit    = 3'h0;
    d.word    = 9'h000;
    if (off < `DCC_SEC_BUF_BASE) begin
      rel      = off - `DCC_PRI_BUF_BASE;
      d.region = DCC_REG_PRI_BUF;
      d.unit   = rel[11:9] + 3'h1;
      d.word   = rel[8:0];
    end else if (off < `DCC_PRI_CUR_BASE) begin
      rel      = off - `DCC_SEC_BUF_BASE;
      d.region = DCC_REG_SEC_BUF;
      d.unit   = rel[8:6] + 3'h1;
      d.word   = {3'h0, rel[5:0]};
    end else if (off < `DCC_SEC_CUR_BASE) begin
      rel      = off - `DCC_PRI_CUR_BASE;
      d.region = DCC_REG_PRI_CUR;
      d.unit   = rel[5:3] + 3'h1;
      d.word   = {6'h00, rel[2:0]};
    end else if (off != `DCC_UNUSED_WORD) begin
      rel      = off - `DCC_SEC_CUR_BASE;
      d.region = DCC_REG_SEC_CUR;
      d.unit   = rel[2:0] + 3'h1;
    end
    return d;
  endfunction

  logic [14:0] addr_q;
  logic [14:0] next_addr;
  logic        offs_q;
  logic        next_offs;
  logic        load_q;
  logic        next_load;
  dcc_decode_s dec_q;
  dcc_decode_s next_dec;

  always_comb begin
    next_addr = addr_q;
    next_offs = offs_q;
    next_dec  = dec_q;
    next_load = 1'b0;
    if (rise_addr && sel_nc) begin
      next_addr = output_word_channel[14:0];
      next_offs = output_word_channel[`DCC_WC_OFFSET_BIT];
      next_dec  = dcc_map(output_word_channel[14:0]);
      next_load = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_q <= `DCC_RST_ADDR;
      offs_q <= 1'b0;
      load_q <= 1'b0;
      dec_q  <= '0;
    end else begin
      addr_q <= next_addr;
      offs_q <= next_offs;
      load_q <= next_load;
      dec_q  <= next_dec;
    end
  end

  assign start_addr  = addr_q;
  assign offset_mode = offs_q;
  assign addr_load   = load_q;
  assign addr_decode = dec_q;

  // ----------------------------------------------------------------------
  // data lines: word channel gated through while select is set
  // ----------------------------------------------------------------------
  logic [15:0] data_q;
  logic [15:0] next_data;
  logic [1:0]  par_q;
  logic [1:0]  next_par;
  logic        sel_q;

  always_comb begin
    next_data = `DCC_RST_DATA;
    next_par  = 2'h0;
    if (sel_nc) begin
      next_data = output_word_channel;
      next_par  = {output_control_channel[`DCC_CC_PAR_LEFT], output_control_channel[`DCC_CC_PAR_RIGHT]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_q <= `DCC_RST_DATA;
      par_q  <= 2'h0;
      sel_q  <= 1'b0;
    end else begin
      data_q <= next_data;
      par_q  <= next_par;
      sel_q  <= sel_nc;
    end
  end

  assign unit_data   = data_q;
  assign unit_parity = par_q;
  assign nc_data_sel = sel_q;

  // ----------------------------------------------------------------------
  // compare termination
  // ----------------------------------------------------------------------
  logic [6:0] cmp_char;
  logic       char_mode;
  logic       dbl_mode;
  logic       lock_term;
  logic       match;
  logic       hit_q;
  logic       next_hit;
  logic       stop_q;
  logic       next_stop;

  // byte of the data stream that ends a transfer under the current mode
  function automatic logic dcc_byte_hit(input logic [6:0] b, input logic [6:0] c,
                                        input logic cm, input logic dm);
    logic h;
    h = 1'b0;
    if (cm && b == c) begin
      h = 1'b1;
    end
    if (dm && (b == `DCC_CODE_EOF || b == `DCC_CODE_EOR)) begin
      h = 1'b1;
    end
    return h;
  endfunction

  always_comb begin
    cmp_char  = output_word_channel[6:0];
    char_mode = output_control_channel[`DCC_CC_SEL_CHAR_CMP];
    dbl_mode  = output_control_channel[`DCC_CC_SEL_DBL_CMP];
    lock_term = output_control_channel[`DCC_CC_LOCK_TERM];
    match     = xfer_valid & ~lock_term &
                (dcc_byte_hit(xfer_data[14:8], cmp_char, char_mode, dbl_mode) |
                 dcc_byte_hit(xfer_data[6:0], cmp_char, char_mode, dbl_mode));
    next_hit  = hit_q;
    if (next_load) begin
      next_hit = 1'b0;
    end
    if (match) begin
      next_hit = 1'b1; // set wins over the new-address clear
    end
    next_stop = match & ~hit_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hit_q  <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      hit_q  <= next_hit;
      stop_q <= next_stop;
    end
  end

  assign compare_hit = hit_q;
  assign xfer_stop   = stop_q;

endmodule // dcc_channel_ctrl

// ===== verification/dcc_channel_ctrl_sva.sv
`timescale 1ns/1ps
module dcc_chk
  import dcc_pkg::*;
#(
  parameter int KB_PER_GROUP = 7,
  parameter int NUM_GROUPS   = 4
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // channels
  input wire logic [15:0] output_word_channel,
  input wire logic [15:0] output_control_channel,
  // results
  input wire dcc_ind_s    indicators,
  input wire logic [14:0] start_addr,
  input wire logic        offset_mode,
  input wire logic        addr_load,
  input wire logic        nc_data_sel,
  input wire logic [15:0] unit_data,
  input wire logic [1:0]  unit_parity,
  input wire logic        compare_hit,
  input wire logic        xfer_stop
);
  wire logic [15:0] w = output_word_channel;
  wire logic [15:0] c = output_control_channel;
  // position bits 9..f to keyboard order
  function automatic logic [6:0] pos(input logic [15:0] v);
    for (int i = 0; i < 7; i++) pos[i] = v[6-i];
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_addr_strobe;
    $rose(c[14]) && c[12];
  endsequence
  a_lock_lo: assert property ($rose(c[5]) |=> indicators.lockout[6:0] == (pos($past(w)) & {7{$past(w[15])}}))
    else $error("lockout lower group load wrong");
  a_alert_hi: assert property ($rose(c[6]) |=> indicators.alert[27:21] == (pos($past(w)) & {7{$past(w[12])}}))
    else $error("alert upper group load wrong");
  a_buzz_hi: assert property ($rose(c[5]) |=> indicators.buzzer[13:7] == (pos($past(w)) & {7{$past(w[10])}}))
    else $error("buzzer group 1 load wrong");
  a_ind_hold: assert property (!($rose(c[5]) || $rose(c[6])) |=> $stable(indicators))
    else $error("indicators changed without strobe");
  a_addr_take: assert property (s_addr_strobe |=> addr_load && start_addr == $past(w[14:0])
    && offset_mode == $past(w[15]))
    else $error("address not captured");
  a_addr_none: assert property (!($rose(c[14]) && c[12]) |=> !addr_load)
    else $error("address load without strobe");
  a_data_pass: assert property (c[12] |=> nc_data_sel && unit_data == $past(w)
    && unit_parity == $past(c[11:10]))
    else $error("data lines not passed");
  a_data_block: assert property (!c[12] |=> !nc_data_sel && unit_data == 16'h0000)
    else $error("data lines not blocked");
  a_stop_once: assert property (xfer_stop |-> compare_hit ##1 !xfer_stop)
    else $error("stop pulse wrong");
endmodule // dcc_chk

// ===== verification/dcc_stn_model.sv
`timescale 1ns/1ps
module dcc_stn_model (
  // clock
  input  wire logic   clk,
  // channels toward the coupler
  output logic [15:0] output_word_channel,
  output logic [15:0] output_control_channel
);
  initial begin
    output_word_channel = 16'h0000;
    output_control_channel = 16'h0000;
  end
  // stage word, then set and clear the strobe bits given in s
  task automatic pulse(input logic [15:0] w, input logic [15:0] base, input logic [15:0] s);
    @(posedge clk);
    output_word_channel <= w;
    output_control_channel <= base;
    @(posedge clk);
    output_control_channel <= base | s;
    @(posedge clk);
    output_control_channel <= base;
  endtask
  // level setting held for a whole transfer
  task automatic hold(input logic [15:0] w, input logic [15:0] c);
    @(posedge clk);
    output_word_channel <= w;
    output_control_channel <= c;
  endtask
endmodule // dcc_stn_model

// ===== verification/tb_display_coupler_channel_ctrl.sv
`timescale 1ns/1ps
module tb_display_coupler_channel_ctrl
  import dcc_pkg::*;
;
  logic        clk, rstn, xfer_valid, om, al, nds, hit, stop;
  logic [15:0] xfer_data, ud, lw;
  wire  [15:0] ow, oc;
  dcc_ind_s    ind;
  dcc_decode_s dec;
  logic [14:0] sa;
  logic [1:0]  up;
  int          fail_count, n_compared, seed, cyc;
  int          m[3][28];
  logic [83:0] e;
  logic [11:0] offs[12] = '{12'h000, 12'h1ff, 12'h200, 12'he00, 12'he3f, 12'he40, 12'hfc0, 12'hfc7,
                            12'hfc8, 12'hff8, 12'hffe, 12'hfff};

  dcc_channel_ctrl dut (.clk, .rstn, .output_word_channel(ow), .output_control_channel(oc), .xfer_data,
    .xfer_valid, .indicators(ind), .start_addr(sa), .offset_mode(om), .addr_load(al), .addr_decode(dec),
    .nc_data_sel(nds), .unit_data(ud), .unit_parity(up), .compare_hit(hit), .xfer_stop(stop));
  dcc_stn_model stn (.clk, .output_word_channel(ow), .output_control_channel(oc));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [83:0] got, input logic [83:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // reference models
  // ----------------------------------------------------------------------
  task automatic ind_load(input logic [15:0] w, input logic [15:0] s);
    for (int g = 0; g < 2; g++)
      if (s[5+g])
        for (int t = 0; t < 3; t++)
          for (int k = 0; k < 14; k++)
            m[t][14*g+k] = w[15-2*t-k/7] & w[6-k%7];
    for (int t = 0; t < 3; t++)
      for (int k = 0; k < 28; k++)
        e[56-28*t+k] = m[t][k][0];
    stn.pulse(w, 16'h0000, s);
    #1 chk(ind, e, "indicator pattern");
  endtask
  task automatic addr_run(input logic [15:0] w);
    logic [11:0] a;
    dcc_decode_s d;
    a = w[11:0];
    if (a < 12'he00) d = '{DCC_REG_PRI_BUF, w[13:12], a[11:9] + 3'h1, a[8:0]};
    else if (a < 12'hfc0) d = '{DCC_REG_SEC_BUF, w[13:12], a[8:6] + 3'h1, {3'h0, a[5:0]}};
    else if (a < 12'hff8) d = '{DCC_REG_PRI_CUR, w[13:12], a[5:3] + 3'h1, {6'h00, a[2:0]}};
    else if (a < 12'hfff) d = '{DCC_REG_SEC_CUR, w[13:12], a[2:0] + 3'h1, 9'h000};
    else d = '{DCC_REG_UNUSED, w[13:12], 3'h0, 9'h000};
    stn.pulse(w, 16'h1000, 16'h4000);
    #1 chk(al, 1, "address strobe");
    chk({om, sa}, w, "address value");
    chk(dec, d, "address decode");
    lw = w;
  endtask
  task automatic cmp_run(input logic [15:0] c, input logic [6:0] ch, input logic [15:0] hd, input bit h);
    stn.pulse(16'h0000, 16'h1000, 16'h4000);
    stn.hold({1'b0, ch, 1'b0, ch}, c);
    @(posedge clk);
    xfer_data <= 16'h0000;
    xfer_valid <= 1'b1;
    @(posedge clk);
    xfer_data <= hd;
    #1 chk({hit, stop}, 0, "false hit");
    @(posedge clk);
    xfer_valid <= 1'b0;
    #1 chk({hit, stop}, {2{h}}, "hit result");
    @(posedge clk);
    #1 chk({hit, stop}, {h, 1'b0}, "stop pulse");
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [6:0] ch;
    logic [15:0] pw;
    rstn = 1'b0;
    xfer_data = 16'h0000;
    xfer_valid = 1'b0;
    seed = 32'h9047;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    ind_load(16'h8020, 16'h0020);
    ind_load(16'h8020, 16'h0040);
    for (int i = 0; i < 12; i++) ind_load(16'($random(seed)), 16'h0020 * 16'(i % 3 + 1));
    repeat (3) @(posedge clk);
    #1 chk(ind, e, "indicator hold");
    $display("indicator test done");
    for (int i = 0; i < 12; i++) addr_run({4'($random(seed)), offs[i]});
    stn.pulse(16'h1234, 16'h0000, 16'h4000);
    #1 chk({al, om, sa}, {1'b0, lw}, "refused address");
    $display("address test done");
    ch = 7'($random(seed)) | 7'h01;
    cmp_run(16'h0200, ch, {9'h000, ch}, 1'b1);
    cmp_run(16'h0080, 7'h1c, 16'h1f00, 1'b1);
    cmp_run(16'h0080, 7'h1f, 16'h001c, 1'b1);
    cmp_run(16'h2200, ch, {1'b0, ch, 8'h00}, 1'b0);
    pw = 16'($random(seed));
    stn.hold(pw, 16'h1800);
    @(posedge clk);
    #1 chk({nds, up, ud}, {1'b1, 2'b10, pw}, "pattern word");
    stn.hold(pw, 16'h0000);
    @(posedge clk);
    #1 chk({nds, up, ud}, 0, "data lines blocked");
    repeat (4) @(posedge clk);
    $display("compare and pattern test done");
    finish_test();
  end
endmodule // tb_display_coupler_channel_ctrl

bind dcc_channel_ctrl dcc_chk #(.KB_PER_GROUP(KB_PER_GROUP), .NUM_GROUPS(NUM_GROUPS)) u_chk (.clk, .rstn,
  .output_word_channel, .output_control_channel, .indicators, .start_addr, .offset_mode, .addr_load,
  .nc_data_sel, .unit_data, .unit_parity, .compare_hit, .xfer_stop);
